// >>> src/timer_control_command_decoder.sv
/*
   Command decoder of a five-counter timing controller, with its register port.
   Assumes a plain synchronous register port: one-cycle strobes, read data in the following cycle.
*/
// Our own choices: strobed register access and the register offsets.
// Function
// [R1] Code EE sets gate bit 12 only
// [R2] Gate bit set holds output low
// [R3] Code E6 clears gate bit 12 only
// [R4] Gate bit clear drives divided source
// [R5] Full master mode write updates gate bit
// [R6] Gating change may glitch the output
// [R7] Code F9 disables write prefetch only
// [R8] Prefetch off shortens write recovery
// [R9] Prefetch stays off until F8 or reset
// [R10] Code F8 re-enables write prefetch
// [R11] Code FF equals power-on reset
// [R12] Reset disarms, zeroes master, load, hold
// [R13] Reset loads 0800 into counter modes
// [R14] Reset leaves access pointer unchanged
// [R15] Host loads all counters after reset
// [R16] Host sets pointer before initialising registers
// [R17] Counter in TC counts once to leave
// [R18] Only decoded commands change gate, prefetch
`timescale 1ns/1ps
`include "tcd_map.svh"

module timer_control_command_decoder
   import tcd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input bus_req_t bus_req,
   input wire logic [4:0] src_tick,
   output logic [15:0] rd_data,
   output logic freq_output,
   output logic write_busy,
   output logic [4:0] tc_state
);

   localparam int REC_PF_CYC = `TCD_TWR_PF_CYC;
   localparam int REC_NOPF_CYC = `TCD_TWR_NOPF_CYC;

   logic [15:0] mm_ff;
   logic [15:0] nxt_mm;
   logic [7:0] ptr_ff;
   logic pf_off_ff;
   logic [15:0] rd_data_ff;
   logic write_busy_ff;
   logic [4:0] tc_state_ff;
   rec_state_t rec_state_ff;
   logic [8:0] rec_cnt_ff;

   logic cmd_wr;
   logic [7:0] cmd_code;
   logic soft_rst;
   logic [4:0] load_sel;
   logic [4:0] arm_sel;
   logic cnt_hit;
   logic [2:0] cnt_idx;
   logic [3:0] cnt_sub;
   logic [4:0] wr_mode;
   logic [4:0] wr_load;
   logic [4:0] wr_hold;
   cnt_view_t cnt_view [`TCD_NUM_CNT];

   assign cmd_wr = bus_req.wr && (bus_req.addr == `TCD_ADDR_CMD);
   assign cmd_code = bus_req.wdata[7:0];
   assign soft_rst = cmd_wr && (cmd_code == `TCD_CMD_MRESET); // [R11]
   assign load_sel = (cmd_wr && cmd_code[7:5] == `TCD_CMD_LOAD_HI) ? cmd_code[4:0] : 5'h00;
   assign arm_sel = (cmd_wr && cmd_code[7:5] == `TCD_CMD_ARM_HI) ? cmd_code[4:0] : 5'h00;

   assign cnt_idx = bus_req.addr[6:4];
   assign cnt_sub = bus_req.addr[3:0];
   assign cnt_hit = !bus_req.addr[7] && (cnt_idx >= `TCD_CNT_FIRST) && (cnt_idx <= `TCD_CNT_LAST);

   // Per-counter register write strobes
   always_comb
   begin
      wr_mode = 5'h00;
      wr_load = 5'h00;
      wr_hold = 5'h00;
      if (bus_req.wr && cnt_hit)
      begin
         if (cnt_sub == `TCD_SUB_MODE)
            wr_mode[3'(cnt_idx - `TCD_CNT_FIRST)] = 1'b1;
         else if (cnt_sub == `TCD_SUB_LOAD)
            wr_load[3'(cnt_idx - `TCD_CNT_FIRST)] = 1'b1;
         else if (cnt_sub == `TCD_SUB_HOLD)
            wr_hold[3'(cnt_idx - `TCD_CNT_FIRST)] = 1'b1;
      end
   end

   // Master mode next value; gate commands only touch the gate bit, master reset reloads the whole word
   always_comb
   begin
      nxt_mm = mm_ff;
      if (soft_rst)
         nxt_mm = `TCD_MM_RST; // [R12]
      else if (cmd_wr && cmd_code == `TCD_CMD_GATE_OFF)
         nxt_mm[`TCD_MM_GATE_BIT] = 1'b1; // [R1]
      else if (cmd_wr && cmd_code == `TCD_CMD_GATE_ON)
         nxt_mm[`TCD_MM_GATE_BIT] = 1'b0; // [R3]
      else if (bus_req.wr && bus_req.addr == `TCD_ADDR_MM)
         nxt_mm = bus_req.wdata; // [R5]
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         mm_ff <= `TCD_MM_RST;
      else
         mm_ff <= nxt_mm; // [R18]
   end

   // The pointer has no reset meaning; a soft reset must not touch it
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         ptr_ff <= `TCD_PTR_RST;
      else if (bus_req.wr && bus_req.addr == `TCD_ADDR_PTR)
         ptr_ff <= bus_req.wdata[7:0]; // [R14] [R16]
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         pf_off_ff <= 1'b0;
      else if (soft_rst)
         pf_off_ff <= 1'b0; // [R9]
      else if (cmd_wr && cmd_code == `TCD_CMD_PF_OFF)
         pf_off_ff <= 1'b1; // [R7]
      else if (cmd_wr && cmd_code == `TCD_CMD_PF_ON)
         pf_off_ff <= 1'b0; // [R10]
   end

   // Write recovery: prefetch after a write keeps the device busy far longer than without it
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rec_state_ff <= REC_IDLE;
         rec_cnt_ff <= 9'h000;
         write_busy_ff <= 1'b0;
      end
      else if (bus_req.wr)
      begin
         rec_state_ff <= REC_BUSY;
         write_busy_ff <= 1'b1;
         if (pf_off_ff)
            rec_cnt_ff <= 9'(REC_NOPF_CYC - 1); // [R8]
         else
            rec_cnt_ff <= 9'(REC_PF_CYC - 1);
      end
      else
      begin
         case (rec_state_ff)
            REC_IDLE:
            begin
               write_busy_ff <= 1'b0;
            end
            REC_BUSY:
            begin
               if (rec_cnt_ff == 9'h000)
               begin
                  rec_state_ff <= REC_IDLE;
                  write_busy_ff <= 1'b0;
               end
               else
                  rec_cnt_ff <= rec_cnt_ff - 9'h001;
            end
            default:
            begin
               rec_state_ff <= REC_IDLE;
               write_busy_ff <= 1'b0;
            end
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `TCD_NUM_CNT; gi++)
      begin : g_cnt
         counter_slot u_slot (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .soft_rst(soft_rst), // [R12] [R13]
            .load_cmd(load_sel[gi]), // [R15]
            .arm_cmd(arm_sel[gi]),
            .tick(src_tick[gi]),
            .wr_mode(wr_mode[gi]),
            .wr_load(wr_load[gi]),
            .wr_hold(wr_hold[gi]),
            .wdata(bus_req.wdata),
            .view(cnt_view[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         tc_state_ff <= 5'h00;
      else
      begin
         for (int i = 0; i < `TCD_NUM_CNT; i++)
            tc_state_ff[i] <= cnt_view[i].tc;
      end
   end

   // Read path; unmapped offsets read zero
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         rd_data_ff <= 16'h0000;
      else if (!bus_req.rd)
         rd_data_ff <= 16'h0000;
      else if (bus_req.addr == `TCD_ADDR_MM)
         rd_data_ff <= mm_ff;
      else if (bus_req.addr == `TCD_ADDR_PTR)
         rd_data_ff <= {8'h00, ptr_ff};
      else if (bus_req.addr == `TCD_ADDR_STAT)
         rd_data_ff <= {mm_ff[`TCD_MM_GATE_BIT], pf_off_ff, write_busy_ff, 3'h0,
                        cnt_view[4].armed, cnt_view[3].armed, cnt_view[2].armed,
                        cnt_view[1].armed, cnt_view[0].armed, tc_state_ff};
      else if (cnt_hit && cnt_sub == `TCD_SUB_MODE)
         rd_data_ff <= cnt_view[3'(cnt_idx - `TCD_CNT_FIRST)].mode;
      else if (cnt_hit && cnt_sub == `TCD_SUB_LOAD)
         rd_data_ff <= cnt_view[3'(cnt_idx - `TCD_CNT_FIRST)].load;
      else if (cnt_hit && cnt_sub == `TCD_SUB_HOLD)
         rd_data_ff <= cnt_view[3'(cnt_idx - `TCD_CNT_FIRST)].hold;
      else if (cnt_hit && cnt_sub == `TCD_SUB_COUNT)
         rd_data_ff <= cnt_view[3'(cnt_idx - `TCD_CNT_FIRST)].count;
      else
         rd_data_ff <= 16'h0000;
   end

   freq_gate u_freq_output (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .gate_off(mm_ff[`TCD_MM_GATE_BIT]), // [R2] [R4]
      .div_sel(mm_ff[`TCD_MM_DIV_HI:`TCD_MM_DIV_LO]),
      .freq_output(freq_output)
   );

   assign rd_data = rd_data_ff;
   assign write_busy = write_busy_ff;
   assign tc_state = tc_state_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_cmd(logic [7:0] code);
      cmd_wr && cmd_code == code;
   endsequence

   sequence s_write_pf_on;
      bus_req.wr && !pf_off_ff;
   endsequence

   sequence s_write_pf_off_alone;
      (bus_req.wr && pf_off_ff) ##1 !bus_req.wr;
   endsequence

   chk_gate_off_cmd: assert property (s_cmd(`TCD_CMD_GATE_OFF) |=> // [R1]
      mm_ff[`TCD_MM_GATE_BIT] && (mm_ff[11:0] == $past(mm_ff[11:0])) && (mm_ff[15:13] == $past(mm_ff[15:13])))
      else $error("gate off command did not set only the gate bit");

   chk_gate_on_cmd: assert property (s_cmd(`TCD_CMD_GATE_ON) |=> // [R3]
      !mm_ff[`TCD_MM_GATE_BIT] && (mm_ff[11:0] == $past(mm_ff[11:0])) && (mm_ff[15:13] == $past(mm_ff[15:13])))
      else $error("gate on command did not clear only the gate bit");

   chk_gate_holds_low: assert property (mm_ff[`TCD_MM_GATE_BIT] |=> !freq_output) // [R2]
      else $error("frequency output not low while gated off");

   chk_mm_word_write: assert property ((bus_req.wr && bus_req.addr == `TCD_ADDR_MM) |=> // [R5]
      mm_ff == $past(bus_req.wdata))
      else $error("master mode word write not stored");

   chk_pf_off_cmd: assert property (s_cmd(`TCD_CMD_PF_OFF) |=> pf_off_ff) // [R7]
      else $error("prefetch not disabled by its command");

   chk_pf_stays_off: assert property ((pf_off_ff && !(cmd_wr && cmd_code == `TCD_CMD_PF_ON) // [R9]
      && !soft_rst) |=> pf_off_ff)
      else $error("write prefetch re-enabled without command or reset");

   chk_pf_on_cmd: assert property (s_cmd(`TCD_CMD_PF_ON) |=> !pf_off_ff) // [R10]
      else $error("prefetch not re-enabled by its command");

   chk_recovery_long: assert property (s_write_pf_on ##1 !bus_req.wr [*7] |-> // [R8]
      write_busy_ff)
      else $error("write recovery with prefetch ended early");

   chk_recovery_short: assert property (s_write_pf_off_alone |=> !write_busy_ff) // [R8]
      else $error("write recovery without prefetch not one cycle");

   chk_master_reset: assert property (soft_rst |=> (mm_ff == `TCD_MM_RST) && !pf_off_ff // [R11] [R12]
      && cnt_view[0].load == `TCD_LOAD_RST && cnt_view[4].hold == `TCD_HOLD_RST
      && !cnt_view[2].armed && (ptr_ff == $past(ptr_ff))) // [R14]
      else $error("master reset left state wrong");

   chk_mode_default: assert property (soft_rst |=> cnt_view[0].mode == `TCD_MODE_RST // [R13]
      && cnt_view[4].mode == `TCD_MODE_RST)
      else $error("counter mode not defaulted by master reset");

   chk_tc_leave: assert property ((src_tick[0] && cnt_view[0].tc && !load_sel[0]) |=> // [R17]
      !cnt_view[0].tc && cnt_view[0].count == $past(cnt_view[0].load))
      else $error("counter did not leave terminal count on one count");

   chk_other_codes: assert property ((cmd_wr && !(cmd_code inside {`TCD_CMD_GATE_OFF, `TCD_CMD_GATE_ON, // [R18]
      `TCD_CMD_PF_OFF, `TCD_CMD_PF_ON, `TCD_CMD_MRESET})) |=> $stable(pf_off_ff) && $stable(mm_ff))
      else $error("undecoded command changed gate or prefetch state");

endmodule : timer_control_command_decoder

// >>> inc/tcd_map.svh
/*
   Register offsets, command codes, reset values and timing counts of the timer command decoder.
   Assumes a 200 MHz system clock and a 16-bit register port with byte offsets.
*/
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH

`define TCD_NUM_CNT 5
`define TCD_ADDR_CMD 8'h00
`define TCD_ADDR_MM 8'h04
`define TCD_ADDR_PTR 8'h08
`define TCD_ADDR_STAT 8'h0c
`define TCD_CNT_FIRST 3'h1
`define TCD_CNT_LAST 3'h5
`define TCD_SUB_MODE 4'h0
`define TCD_SUB_LOAD 4'h4
`define TCD_SUB_HOLD 4'h8
`define TCD_SUB_COUNT 4'hc

`define TCD_CMD_GATE_OFF 8'hee
`define TCD_CMD_GATE_ON 8'he6
`define TCD_CMD_PF_OFF 8'hf9
`define TCD_CMD_PF_ON 8'hf8
`define TCD_CMD_MRESET 8'hff
`define TCD_CMD_LOAD_HI 3'h2
`define TCD_CMD_ARM_HI 3'h1

`define TCD_MM_GATE_BIT 12
`define TCD_MM_DIV_HI 11
`define TCD_MM_DIV_LO 8
`define TCD_MM_RST 16'h0000
`define TCD_LOAD_RST 16'h0000
`define TCD_HOLD_RST 16'h0000
`define TCD_MODE_RST 16'h0800
`define TCD_PTR_RST 8'h00
`define TCD_DIV_FULL 5'h10

`define TCD_CLK_NS 5
`define TCD_TWR_PF_NS 1500
`define TCD_TWR_NOPF_NS 5
`define TCD_TWR_PF_CYC (((`TCD_TWR_PF_NS) + (`TCD_CLK_NS) - 1) / (`TCD_CLK_NS))
`define TCD_TWR_NOPF_CYC (((`TCD_TWR_NOPF_NS) + (`TCD_CLK_NS) - 1) / (`TCD_CLK_NS))

`endif

// >>> inc/tcd_pkg.sv
/*
   Types shared by the timer command decoder and its counter and output modules.
   Assumes tcd_map.svh for all numeric values.
*/
package tcd_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] load;
      logic [15:0] hold;
      logic [15:0] count;
      logic armed;
      logic tc;
   } cnt_view_t;

   typedef enum logic [1:0] {
      REC_IDLE = 2'b00,
      REC_BUSY = 2'b01
   } rec_state_t;

endpackage : tcd_pkg

// >>> src/counter_slot.sv
/*
   One counter: mode, load and hold registers, arm state, count and terminal-count state.
   Assumes one-cycle command pulses from the decoder and a synchronous count tick.
*/
`timescale 1ns/1ps
`include "tcd_map.svh"

module counter_slot
   import tcd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic load_cmd,
   input wire logic arm_cmd,
   input wire logic tick,
   input wire logic wr_mode,
   input wire logic wr_load,
   input wire logic wr_hold,
   input wire logic [15:0] wdata,
   output cnt_view_t view
);

   logic [15:0] mode_ff;
   logic [15:0] load_ff;
   logic [15:0] hold_ff;
   logic [15:0] count_ff;
   logic armed_ff;
   logic tc_ff;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_ff <= `TCD_MODE_RST;
         load_ff <= `TCD_LOAD_RST;
         hold_ff <= `TCD_HOLD_RST;
      end
      else if (soft_rst)
      begin
         mode_ff <= `TCD_MODE_RST;
         load_ff <= `TCD_LOAD_RST;
         hold_ff <= `TCD_HOLD_RST;
      end
      else
      begin
         if (wr_mode)
            mode_ff <= wdata;
         if (wr_load)
            load_ff <= wdata;
         if (wr_hold)
            hold_ff <= wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         armed_ff <= 1'b0;
      else if (soft_rst)
         armed_ff <= 1'b0;
      else if (arm_cmd)
         armed_ff <= 1'b1;
   end

   // Count and TC survive a soft reset; apart from sys_rst, only a load or one count clears TC
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         count_ff <= 16'h0000;
         tc_ff <= 1'b0;
      end
      else if (load_cmd)
      begin
         count_ff <= load_ff;
         tc_ff <= 1'b0;
      end
      else if (tick && tc_ff)
      begin
         count_ff <= load_ff; // [R17]
         tc_ff <= 1'b0; // [R17]
      end
      else if (tick && armed_ff)
      begin
         count_ff <= count_ff - 16'h0001;
         tc_ff <= (count_ff == 16'h0001);
      end
   end

   assign view = '{mode: mode_ff, load: load_ff, hold: hold_ff, count: count_ff, armed: armed_ff, tc: tc_ff};

endmodule : counter_slot

// >>> src/freq_gate.sv
/*
   Frequency output: divides the system clock and gates the result.
   Assumes the gate bit and divider field come straight from the master mode register.
*/
`timescale 1ns/1ps
`include "tcd_map.svh"

module freq_gate
   import tcd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic gate_off,
   input wire logic [3:0] div_sel,
   output logic freq_output
);

   logic [4:0] div_cnt_ff;
   logic div_out_ff;
   logic freq_output_ff;
   logic [4:0] div_top;

   // A divider field of zero means divide by thirty-two
   assign div_top = (div_sel == 4'h0) ? `TCD_DIV_FULL : {1'b0, div_sel};

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         div_cnt_ff <= 5'h00;
         div_out_ff <= 1'b0;
      end
      else if (div_cnt_ff + 5'h01 >= div_top)
      begin
         div_cnt_ff <= 5'h00;
         div_out_ff <= ~div_out_ff;
      end
      else
         div_cnt_ff <= div_cnt_ff + 5'h01;
   end

   // Gating is not synchronised to the divider phase, so a short pulse can appear at the switch
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         freq_output_ff <= 1'b0;
      else if (gate_off)
         freq_output_ff <= 1'b0; // [R2]
      else
         freq_output_ff <= div_out_ff; // [R4] [R6]
   end

   assign freq_output = freq_output_ff;

endmodule : freq_gate

// >>> verif/host_model.sv
/*
   Host processor model: drives the register port with one-cycle write and read strobes,
   and runs the start-up sequence that follows any reset.
   Assumes read data stand in the cycle after the read strobe, and a 16-bit port.
*/
`timescale 1ns/1ps
`include "tcd_map.svh"

module host_model
   import tcd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [15:0] rd_data,
   output bus_req_t bus_req
);
   initial bus_req = '0;

   // Released lines show the inverse, so stale values cannot pass for fresh ones
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
   begin
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
   begin
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
      #1 d = rd_data;
   end
   endtask : rd

   // A counter left in terminal count would otherwise stay there until its next count
   task automatic start_up(input logic [7:0] ptr);
   begin
      wr(`TCD_ADDR_CMD, 16'h005f);
      wr(`TCD_ADDR_PTR, {8'h00, ptr});
   end
   endtask : start_up
endmodule : host_model

// >>> verif/timer_control_command_decoder_tb_top.sv
/*
   Self-checking bench of the timer command decoder: gate, prefetch and master reset commands.
   Assumes host_model on the register port and counter ticks driven by the bench.
*/
`timescale 1ns/1ps
`include "tcd_map.svh"

module timer_control_command_decoder_tb_top
   import tcd_pkg::*;
;
   logic clk_sys;
   logic sys_rst;
   logic [4:0] src_tick;
   bus_req_t bus_req;
   logic [15:0] rd_data;
   logic freq_output;
   logic write_busy;
   logic [4:0] tc_state;
   integer seed;
   int bad_count;
   int n_compared;
   int ones;
   int n;
   logic [15:0] v;
   logic [15:0] mm;
   logic [7:0] code;

   timer_control_command_decoder dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
      .src_tick(src_tick), .rd_data(rd_data), .freq_output(freq_output), .write_busy(write_busy),
      .tc_state(tc_state));
   host_model host_u (.clk_sys(clk_sys), .rd_data(rd_data), .bus_req(bus_req));

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
   begin
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   end
   endtask : check

   task automatic results;
   begin
      $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask : results

   function automatic logic [15:0] gate_cmd(input logic [15:0] old, input logic [7:0] c);
      logic [15:0] m;
      m = 16'h0001 << `TCD_MM_GATE_BIT;
      return (c == `TCD_CMD_GATE_OFF) ? (old | m) : (old & ~m);
   endfunction : gate_cmd

   task automatic check_defaults;
   begin
      for (int i = 1; i <= `TCD_NUM_CNT; i++)
      begin
         host_u.rd({i[3:0], `TCD_SUB_MODE}, v);
         check(v, `TCD_MODE_RST);
         host_u.rd({i[3:0], `TCD_SUB_LOAD}, v);
         check(v, `TCD_LOAD_RST);
         host_u.rd({i[3:0], `TCD_SUB_HOLD}, v);
         check(v, `TCD_HOLD_RST);
      end
      host_u.rd(`TCD_ADDR_MM, v);
      check(v, `TCD_MM_RST);
   end
   endtask : check_defaults

   task automatic count_ones(input int cycles, output int cnt);
   begin
      cnt = 0;
      repeat (cycles)
      begin
         @(posedge clk_sys);
         #1;
         if (freq_output === 1'b1)
            cnt++;
      end
   end
   endtask : count_ones

   task automatic pulse_tick(input int i);
   begin
      @(posedge clk_sys);
      src_tick <= 5'h01 << i;
      @(posedge clk_sys);
      src_tick <= 5'h00;
      repeat (3) @(posedge clk_sys);
      #1;
   end
   endtask : pulse_tick

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      $display("wrong value at %0t: run did not finish in time", $time);
      results();
   end

   initial
   begin
      seed = 9;
      bad_count = 0;
      n_compared = 0;
      sys_rst = 1'b1;
      src_tick = 5'h00;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      host_u.start_up(8'h01);
      check_defaults();
      // Gate off and on around random divider settings
      repeat (4)
      begin
         n = 1 + ($unsigned($random(seed)) % 15);
         mm = {4'h0, 4'(n), 8'($random(seed))};
         host_u.wr(`TCD_ADDR_MM, mm);
         code = `TCD_CMD_GATE_OFF;
         host_u.wr(`TCD_ADDR_CMD, {8'h00, code});
         mm = gate_cmd(mm, code);
         host_u.rd(`TCD_ADDR_MM, v);
         check(v, mm);
         count_ones(40, ones);
         check(16'(ones), 16'h0000);
         code = `TCD_CMD_GATE_ON;
         host_u.wr(`TCD_ADDR_CMD, {8'h00, code});
         mm = gate_cmd(mm, code);
         host_u.rd(`TCD_ADDR_MM, v);
         check(v, mm);
         // Skip the switch-over, where a short pulse is tolerated
         repeat (8) @(posedge clk_sys);
         count_ones(16 * n, ones);
         check(16'(ones), 16'(8 * n));
      end
      host_u.wr(`TCD_ADDR_MM, 16'h1000);
      host_u.rd(`TCD_ADDR_STAT, v);
      check({15'h0, v[15]}, 16'h0001);
      // Write prefetch off, then junk codes, then on again
      host_u.wr(`TCD_ADDR_CMD, {8'h00, `TCD_CMD_PF_OFF});
      host_u.rd(`TCD_ADDR_STAT, v);
      check({15'h0, v[14]}, 16'h0001);
      host_u.wr(`TCD_ADDR_PTR, 16'h0003);
      repeat (3) @(posedge clk_sys);
      #1;
      check({15'h0, write_busy}, 16'h0000);
      for (n = 0; n < 12; n++)
      begin
         code = 8'($random(seed));
         if (code inside {`TCD_CMD_GATE_OFF, `TCD_CMD_GATE_ON, `TCD_CMD_PF_OFF, `TCD_CMD_PF_ON, `TCD_CMD_MRESET}
            || code[7:5] == `TCD_CMD_LOAD_HI || code[7:5] == `TCD_CMD_ARM_HI)
            code = 8'hf0;
         host_u.wr(`TCD_ADDR_CMD, {8'h00, code});
      end
      host_u.rd(`TCD_ADDR_STAT, v);
      check({14'h0, v[15:14]}, 16'h0003);
      host_u.wr(`TCD_ADDR_CMD, {8'h00, `TCD_CMD_PF_ON});
      host_u.rd(`TCD_ADDR_STAT, v);
      check({15'h0, v[14]}, 16'h0000);
      host_u.wr(`TCD_ADDR_PTR, 16'h0003);
      repeat (3) @(posedge clk_sys);
      #1;
      check({15'h0, write_busy}, 16'h0001);
      // Counter 1 into terminal count, then master reset with everything dirty
      host_u.wr({4'h1, `TCD_SUB_LOAD}, 16'h0001);
      host_u.wr(`TCD_ADDR_CMD, 16'h0041);
      host_u.wr(`TCD_ADDR_CMD, 16'h003f);
      pulse_tick(0);
      check({11'h0, tc_state}, 16'h0001);
      host_u.wr(`TCD_ADDR_MM, 16'h0a5c);
      host_u.wr(`TCD_ADDR_PTR, 16'h0005);
      host_u.wr({4'h2, `TCD_SUB_MODE}, 16'h1234);
      host_u.wr({4'h3, `TCD_SUB_HOLD}, 16'hbeef);
      host_u.wr(`TCD_ADDR_CMD, {8'h00, `TCD_CMD_PF_OFF});
      host_u.rd(`TCD_ADDR_STAT, v);
      check({11'h0, v[9:5]}, 16'h001f);
      host_u.wr(`TCD_ADDR_CMD, {8'h00, `TCD_CMD_MRESET});
      host_u.rd(`TCD_ADDR_STAT, v);
      check({9'h0, v[15:14], v[9:5]}, 16'h0000);
      check_defaults();
      host_u.rd(`TCD_ADDR_PTR, v);
      check({8'h00, v[7:0]}, 16'h0005);
      check({11'h0, tc_state}, 16'h0001);
      // Disarmed, yet one count still leaves terminal count
      pulse_tick(0);
      check({11'h0, tc_state}, 16'h0000);
      host_u.start_up(8'h01);
      results();
   end
endmodule : timer_control_command_decoder_tb_top
